// >>> hw/rvle_regs.vh
// register map, field layout and reset values of the vertical coefficient and luma enhancer block
// Operation
// - odd tap coefficient, S10Q8, bits 25-16
// - even tap coefficient, S10Q8, bits 9-0
// - filter select bits 17-16: off, 3-tap, 5-tap
// - gain = (|hpf| - core) * slope, clamped
// - luma plus (hpf*gain+8)>>4, clamped 0..255
`ifndef RVLE_REGS_VH
`define RVLE_REGS_VH

// byte offsets on the register bus
`define RVLE_ADDR_W        12
`define RVLE_VCOEF_OFF     12'h000
`define RVLE_ENH_OFF       12'h004
`define RVLE_STAT_OFF      12'h008

// writable bits of each register, reserved bits masked out
`define RVLE_VCOEF_MASK    32'h03ff03ff
`define RVLE_ENH_MASK      32'h0003ffff

// reset values
`define RVLE_VCOEF_RST     32'h00000000
`define RVLE_ENH_RST       32'h00000000

// field positions
`define RVLE_ODD_MSB       25
`define RVLE_ODD_LSB       16
`define RVLE_EVEN_MSB      9
`define RVLE_EVEN_LSB      0
`define RVLE_SEL_MSB       17
`define RVLE_SEL_LSB       16
`define RVLE_GAIN_MSB      15
`define RVLE_GAIN_LSB      12
`define RVLE_SLOPE_MSB     11
`define RVLE_SLOPE_LSB     8
`define RVLE_CORE_MSB      7
`define RVLE_CORE_LSB      0

// filter select codes
`define RVLE_SEL_OFF       2'h0
`define RVLE_SEL_HP3       2'h1
`define RVLE_SEL_HP5       2'h2

// rounding of the enhancement term
`define RVLE_RND           16'sh0008
`define RVLE_RSH           4

// bus responses
`define RVLE_RESP_OKAY     2'h0
`define RVLE_RESP_SLVERR   2'h2

`endif

// >>> hw/rvle_hpf.v
// five-sample luma window and the selectable high-pass filter
`timescale 1ns/10ps
`default_nettype none
`include "rvle_regs.vh"

module rvle_hpf (
    // clock and reset
    input  wire              i_clk,
    input  wire              i_rst,
    input  wire              i_ce,
    // luma stream in
    input  wire              i_valid,
    input  wire        [7:0] i_y,
    input  wire        [1:0] i_sel,
    // centre sample and its filter response
    output reg               o_valid,
    output reg         [7:0] o_y,
    output reg  signed [9:0] o_hpf
);
    reg  [7:0] win_r [0:4];
    integer    k;

    wire signed [11:0] x0 = {4'h0, win_r[0]};
    wire signed [11:0] x1 = {4'h0, win_r[1]};
    wire signed [11:0] x2 = {4'h0, win_r[2]};
    wire signed [11:0] x3 = {4'h0, win_r[3]};
    wire signed [11:0] x4 = {4'h0, win_r[4]};

    // [-1 2 -1]/2 and [-1 -2 6 -2 -1]/4, division by arithmetic shift
    wire signed [11:0] sum3 = (x2 <<< 1) - x1 - x3;
    wire signed [11:0] sum5 = (x2 <<< 2) + (x2 <<< 1) - (x1 <<< 1) - (x3 <<< 1) - x0 - x4;
    wire signed [11:0] h3   = sum3 >>> 1;
    wire signed [11:0] h5   = sum5 >>> 2;

    // window shifts on each accepted sample; response registered behind it
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (k = 0; k < 5; k = k + 1)
                win_r[k] <= 8'h00;
            o_valid <= 1'b0;
            o_y     <= 8'h00;
            o_hpf   <= 10'sh000;
        end else if (i_ce) begin
            if (i_valid) begin
                for (k = 4; k > 0; k = k - 1)
                    win_r[k] <= win_r[k-1];
                win_r[0] <= i_y;
            end
            o_valid <= i_valid;
            o_y     <= win_r[2];
            case (i_sel)
                `RVLE_SEL_HP3: o_hpf <= h3[9:0];
                `RVLE_SEL_HP5: o_hpf <= h5[9:0];
                default:       o_hpf <= 10'sh000; // off and reserved code pass luma
            endcase
        end
    end
endmodule // rvle_hpf

`default_nettype wire

// >>> hw/rvle_enh.v
// coring, slope and gain clamp, then saturating add-back of the high-pass term
`timescale 1ns/10ps
`default_nettype none
`include "rvle_regs.vh"

module rvle_enh (
    // sample and filter response
    input  wire        [7:0] i_y,
    input  wire signed [9:0] i_hpf,
    // enhancer settings
    input  wire        [3:0] i_gain,
    input  wire        [3:0] i_slope,
    input  wire        [7:0] i_core,
    // result
    output reg         [7:0] o_y,
    output reg         [3:0] o_gain
);
    wire        [9:0]  mag   = i_hpf[9] ? (~i_hpf + 10'h001) : i_hpf;
    wire signed [10:0] cored = $signed({1'b0, mag}) - $signed({3'h0, i_core});
    wire signed [15:0] prod  = cored * $signed({1'b0, i_slope});
    wire signed [15:0] lift  = i_hpf * $signed({1'b0, o_gain});
    wire signed [15:0] adj   = (lift + `RVLE_RND) >>> `RVLE_RSH;
    wire signed [15:0] sum   = adj + $signed({8'h00, i_y});

    // gain held between zero and the programmed maximum
    always @* begin
        if (prod < 16'sh0000)
            o_gain = 4'h0;
        else if (prod > $signed({12'h000, i_gain}))
            o_gain = i_gain;
        else
            o_gain = prod[3:0];
    end

    // enhanced luma saturated to eight bits
    always @* begin
        if (sum < 16'sh0000)
            o_y = 8'h00;
        else if (sum > 16'sh00ff)
            o_y = 8'hff;
        else
            o_y = sum[7:0];
    end
endmodule // rvle_enh

`default_nettype wire

// >>> hw/rvle_top.v
// vertical coefficient pair, luma enhancer pipeline and their AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "rvle_regs.vh"

module rvle_top (
    // clock, reset and enable
    input  wire                      i_clk,
    input  wire                      i_rst,
    input  wire                      i_ce,
    // AXI4-Lite write address
    input  wire [`RVLE_ADDR_W-1:0]   i_s_axi_awaddr,
    input  wire                      i_s_axi_awvalid,
    output wire                      o_s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]               i_s_axi_wdata,
    input  wire [3:0]                i_s_axi_wstrb,
    input  wire                      i_s_axi_wvalid,
    output wire                      o_s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0]                o_s_axi_bresp,
    output wire                      o_s_axi_bvalid,
    input  wire                      i_s_axi_bready,
    // AXI4-Lite read address
    input  wire [`RVLE_ADDR_W-1:0]   i_s_axi_araddr,
    input  wire                      i_s_axi_arvalid,
    output wire                      o_s_axi_arready,
    // AXI4-Lite read data
    output wire [31:0]               o_s_axi_rdata,
    output wire [1:0]                o_s_axi_rresp,
    output wire                      o_s_axi_rvalid,
    input  wire                      i_s_axi_rready,
    // luma stream in
    input  wire                      i_pix_valid,
    input  wire [7:0]                i_pix_y,
    // enhanced luma out
    output wire                      o_pix_valid,
    output wire [7:0]                o_pix_y,
    // coefficients to the vertical filter
    output wire [9:0]                o_odd_tap_coef,
    output wire [9:0]                o_even_tap_coef
);
    // register selected by an address
    localparam [1:0] SEL_VCOEF = 2'h0;
    localparam [1:0] SEL_ENH   = 2'h1;
    localparam [1:0] SEL_STAT  = 2'h2;
    localparam [1:0] SEL_NONE  = 2'h3;

    // bus state
    reg                    aw_have_r;
    reg [`RVLE_ADDR_W-1:0] aw_addr_r;
    reg                    w_have_r;
    reg [31:0]             w_data_r;
    reg [3:0]              w_strb_r;
    reg                    awready_r;
    reg                    wready_r;
    reg                    bvalid_r;
    reg [1:0]              bresp_r;
    reg                    arready_r;
    reg                    rvalid_r;
    reg [31:0]             rdata_r;
    reg [1:0]              rresp_r;

    // registers
    reg [31:0]             vcoef_r;
    reg [31:0]             enh_r;

    // pixel output stage
    reg                    pix_valid_r;
    reg [7:0]              pix_y_r;
    reg [3:0]              last_gain_r;
    reg [15:0]             pix_cnt_r;

    // next values
    reg                    aw_have_nxt;
    reg [`RVLE_ADDR_W-1:0] aw_addr_nxt;
    reg                    w_have_nxt;
    reg [31:0]             w_data_nxt;
    reg [3:0]              w_strb_nxt;
    reg                    bvalid_nxt;
    reg [1:0]              bresp_nxt;
    reg                    rvalid_nxt;
    reg [31:0]             rdata_nxt;
    reg [1:0]              rresp_nxt;
    reg [31:0]             vcoef_nxt;
    reg [31:0]             enh_nxt;
    reg                    do_wr;
    reg                    take_ar;
    reg [1:0]              wsel;

    // datapath wires
    wire                   hp_valid;
    wire [7:0]             hp_y;
    wire signed [9:0]      hp_val;
    wire [7:0]             enh_y;
    wire [3:0]             enh_gain;
    wire [31:0]            stat_word;

    // items that move on the write channels at this edge
    wire                   aw_take = i_s_axi_awvalid && awready_r;
    wire                   w_take  = i_s_axi_wvalid && wready_r;

    // map a byte address onto one of the registers
    // low address bits are ignored; a word outside the map selects none
    function [1:0] reg_sel;
        input [`RVLE_ADDR_W-1:0] addr;
        reg   [`RVLE_ADDR_W-1:0] word;
        begin
            word = {addr[`RVLE_ADDR_W-1:2], 2'h0};
            if (word == `RVLE_VCOEF_OFF)
                reg_sel = SEL_VCOEF;
            else if (word == `RVLE_ENH_OFF)
                reg_sel = SEL_ENH;
            else if (word == `RVLE_STAT_OFF)
                reg_sel = SEL_STAT;
            else
                reg_sel = SEL_NONE;
        end
    endfunction

    // byte-lane merge of a write; reserved bits stay zero
    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  strb;
        input [31:0] mask;
        integer      b;
        reg   [31:0] tmp;
        begin
            tmp = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    tmp[b*8 +: 8] = din[b*8 +: 8];
            wmerge = tmp & mask;
        end
    endfunction

    // status word: pixel count, last gain, last enhanced luma
    // the count wraps at 16 bits; gain and luma belong to the newest output
    assign stat_word = {pix_cnt_r, 4'h0, last_gain_r, pix_y_r};

    // write path: address and data caught in either order, answered once both are held;
    // a pending response blocks the next commit, so an unread bresp is never overwritten
    always @* begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt  = w_have_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        if (aw_take) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = i_s_axi_awaddr;
        end
        if (w_take) begin
            w_have_nxt = 1'b1;
            w_data_nxt = i_s_axi_wdata;
            w_strb_nxt = i_s_axi_wstrb;
        end
        do_wr     = aw_have_nxt && w_have_nxt && !bvalid_r;
        wsel      = reg_sel(aw_addr_nxt);
        vcoef_nxt = vcoef_r;
        enh_nxt   = enh_r;
        bresp_nxt = bresp_r;
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bresp_nxt   = `RVLE_RESP_OKAY;
            case (wsel)
                SEL_VCOEF: vcoef_nxt = wmerge(vcoef_r, w_data_nxt, w_strb_nxt, `RVLE_VCOEF_MASK);
                SEL_ENH:   enh_nxt   = wmerge(enh_r, w_data_nxt, w_strb_nxt, `RVLE_ENH_MASK);
                SEL_STAT:  bresp_nxt = `RVLE_RESP_OKAY;   // read-only, write dropped
                default:   bresp_nxt = `RVLE_RESP_SLVERR; // unmapped
            endcase
        end
        bvalid_nxt = do_wr || (bvalid_r && !i_s_axi_bready);
    end

    // read path: one read at a time, data held until taken
    // the word is copied at the taking edge, so a later write does not alter it
    always @* begin
        take_ar   = i_s_axi_arvalid && arready_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (take_ar) begin
            rresp_nxt = `RVLE_RESP_OKAY;
            case (reg_sel(i_s_axi_araddr))
                SEL_VCOEF: rdata_nxt = vcoef_r & `RVLE_VCOEF_MASK;
                SEL_ENH:   rdata_nxt = enh_r & `RVLE_ENH_MASK;
                SEL_STAT:  rdata_nxt = stat_word;
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `RVLE_RESP_SLVERR;
                end
            endcase
        end
        rvalid_nxt = take_ar || (rvalid_r && !i_s_axi_rready);
    end

    // bus and register flip-flops
    // awready or wready is low while its channel holds an item; arready is low while the read answer waits
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= {`RVLE_ADDR_W{1'b0}};
            w_have_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RVLE_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `RVLE_RESP_OKAY;
            vcoef_r   <= `RVLE_VCOEF_RST;
            enh_r     <= `RVLE_ENH_RST;
        end else if (i_ce) begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r  <= w_have_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            awready_r <= !aw_have_nxt;
            wready_r  <= !w_have_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= !rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            vcoef_r   <= vcoef_nxt;
            enh_r     <= enh_nxt;
        end
    end

    // window and high-pass filter
    // filter select acts at the window shift, one edge ahead of the gain settings
    rvle_hpf u_hpf (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_valid (i_pix_valid),
        .i_y     (i_pix_y),
        .i_sel   (enh_r[`RVLE_SEL_MSB:`RVLE_SEL_LSB]),
        .o_valid (hp_valid),
        .o_y     (hp_y),
        .o_hpf   (hp_val)
    );

    // coring, gain and add-back
    // settings come straight from the register, so a change acts on the next sample
    rvle_enh u_enh (
        .i_y     (hp_y),
        .i_hpf   (hp_val),
        .i_gain  (enh_r[`RVLE_GAIN_MSB:`RVLE_GAIN_LSB]),
        .i_slope (enh_r[`RVLE_SLOPE_MSB:`RVLE_SLOPE_LSB]),
        .i_core  (enh_r[`RVLE_CORE_MSB:`RVLE_CORE_LSB]),
        .o_y     (enh_y),
        .o_gain  (enh_gain)
    );

    // output stage: registered luma, last gain and pixel count for status
    // status fields follow only real output samples
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pix_valid_r <= 1'b0;
            pix_y_r     <= 8'h00;
            last_gain_r <= 4'h0;
            pix_cnt_r   <= 16'h0000;
        end else if (i_ce) begin
            pix_valid_r <= hp_valid;
            if (hp_valid) begin
                pix_y_r     <= enh_y;
                last_gain_r <= enh_gain;
                pix_cnt_r   <= pix_cnt_r + 16'h0001; // wraps
            end
        end
    end

    // write channel ports, straight from flip-flops
    assign o_s_axi_awready = awready_r;
    assign o_s_axi_wready  = wready_r;
    assign o_s_axi_bresp   = bresp_r;
    assign o_s_axi_bvalid  = bvalid_r;

    // read channel ports
    assign o_s_axi_arready = arready_r;
    assign o_s_axi_rdata   = rdata_r;
    assign o_s_axi_rresp   = rresp_r;
    assign o_s_axi_rvalid  = rvalid_r;

    // pixel stream ports
    assign o_pix_valid     = pix_valid_r;
    assign o_pix_y         = pix_y_r;

    // coefficient fields fed to the vertical filter as stored
    assign o_odd_tap_coef  = vcoef_r[`RVLE_ODD_MSB:`RVLE_ODD_LSB];
    assign o_even_tap_coef = vcoef_r[`RVLE_EVEN_MSB:`RVLE_EVEN_LSB];

endmodule // rvle_top

`default_nettype wire

// >>> bench/rvle_top_sva.sv
// port assertions of the coefficient pair and luma enhancer top
`timescale 1ns/10ps
`default_nettype none
module rvle_top_sva (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    // register bus
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0]  i_s_axi_wstrb,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic        o_s_axi_bvalid,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_s_axi_rvalid,
    // pixel stream and coefficients
    input wire logic        i_pix_valid,
    input wire logic        o_pix_valid,
    input wire logic [9:0]  o_odd_tap_coef,
    input wire logic [9:0]  o_even_tap_coef
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);
    logic [11:0] rd_addr_r;
    // address of the read under way, needed to judge its data
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) rd_addr_r <= 12'h000;
        else if (i_s_axi_arvalid && o_s_axi_arready) rd_addr_r <= i_s_axi_araddr;
    end
    wire rd_coef = o_s_axi_rvalid && (rd_addr_r[11:2] == 10'h000);
    wire rd_enh  = o_s_axi_rvalid && (rd_addr_r[11:2] == 10'h001);
    // handshake steps of one write and one read
    sequence wr_take;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence ar_take;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    sequence coef_full_wr;
        wr_take ##0 (i_s_axi_awaddr[11:2] == 10'h000 && i_s_axi_wstrb == 4'hf);
    endsequence
    chk_pix_latency: assert property (i_pix_valid |-> ##2 o_pix_valid)
        else $error("output sample missing two cycles after input");
    chk_pix_origin: assert property (o_pix_valid |-> $past(i_pix_valid, 2))
        else $error("output sample without an input sample");
    chk_odd_readback: assert property (rd_coef |-> o_s_axi_rdata[25:16] == o_odd_tap_coef)
        else $error("odd tap port differs from register");
    chk_even_readback: assert property (rd_coef |-> o_s_axi_rdata[9:0] == o_even_tap_coef)
        else $error("even tap port differs from register");
    chk_coef_resv: assert property (rd_coef |-> (o_s_axi_rdata & 32'hfc00fc00) == 32'h0)
        else $error("coefficient spare bits read nonzero");
    chk_enh_resv: assert property (rd_enh |-> o_s_axi_rdata[31:18] == 14'h0)
        else $error("enhancer spare bits read nonzero");
    chk_coef_follow: assert property (coef_full_wr |-> ##2 (o_odd_tap_coef == $past(i_s_axi_wdata[25:16], 2)
        && o_even_tap_coef == $past(i_s_axi_wdata[9:0], 2)))
        else $error("coefficient ports do not follow write");
    chk_wr_answer: assert property (wr_take |=> o_s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (ar_take |=> o_s_axi_rvalid)
        else $error("read data late");
    chk_ce_freeze: assert property (@(posedge i_clk) disable iff (i_rst) !i_ce |=> $stable(o_s_axi_bvalid)
        && $stable(o_s_axi_rvalid) && $stable(o_pix_valid) && $stable(o_odd_tap_coef) && $stable(o_even_tap_coef))
        else $error("state moved while the clock enable was low");
endmodule // rvle_top_sva

bind rvle_top rvle_top_sva rvle_top_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_araddr(i_s_axi_araddr),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_pix_valid(i_pix_valid), .o_pix_valid(o_pix_valid),
    .o_odd_tap_coef(o_odd_tap_coef), .o_even_tap_coef(o_even_tap_coef));
`default_nettype wire

// >>> bench/rvle_top_tb_top.sv
// self-checking bench of the coefficient pair and luma enhancer
`timescale 1ns/10ps
`default_nettype none
`include "rvle_regs.vh"
module rvle_top_tb_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, pix_valid = 1'b0;
    logic        ce = 1'b1, ce_rnd = 1'b0;
    logic [7:0]  pix_y = 8'h00;
    wire         awready, wready, bvalid, arready, rvalid, o_pix_valid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  o_pix_y;
    wire  [9:0]  odd, even;
    int          bad_count = 0, checks = 0, cyc = 0, npix = 0;
    logic [31:0] sh [2] = '{32'h0, 32'h0};
    int          win [5] = '{0, 0, 0, 0, 0};
    logic [11:0] expq [$], last = 12'h0;

    rvle_top rvle_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(1'b1),
        .i_pix_valid(pix_valid), .i_pix_y(pix_y), .o_pix_valid(o_pix_valid), .o_pix_y(o_pix_y),
        .o_odd_tap_coef(odd), .o_even_tap_coef(even));

    // clock at 50 ns
    initial begin
        forever #25 i_clk = ~i_clk;
    end

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // bus write: each channel released at its own handshake, answer awaited
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (awvalid && awready && ce) awvalid <= 1'b0;
            if (wvalid && wready && ce) wvalid <= 1'b0;
            if (bvalid === 1'b1 && ce) begin
                r = bresp;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (arvalid && arready && ce) arvalid <= 1'b0;
            if (rvalid === 1'b1 && ce) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
    endtask

    // strobed byte merge of a register word, spare bits dropped
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s,
                                          input logic [31:0] m);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = d[8*i +: 8];
        return o & m;
    endfunction

    task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_wr(12'(4 * i), d, s, r);
        sh[i] = merge(sh[i], d, s, (i == 0) ? `RVLE_VCOEF_MASK : `RVLE_ENH_MASK);
        cmp("write response", {30'h0, `RVLE_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rd_chk(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(12'(4 * i), d, r);
        cmp("register word", sh[i], d);
        cmp("read response", {30'h0, `RVLE_RESP_OKAY}, {30'h0, r});
    endtask

    // gain and enhanced centre sample of the current window under settings c
    function automatic logic [11:0] model(input logic [31:0] c);
        int h, g, y;
        case (c[17:16])
            2'h1: h = (2 * win[2] - win[1] - win[3]) >>> 1;
            2'h2: h = (6 * win[2] - 2 * win[1] - 2 * win[3] - win[0] - win[4]) >>> 2;
            default: h = 0;
        endcase
        g = ((h < 0 ? -h : h) - int'(c[7:0])) * int'(c[11:8]);
        g = (g < 0) ? 0 : ((g > int'(c[15:12])) ? int'(c[15:12]) : g);
        y = win[2] + ((h * g + 8) >>> 4);
        return {4'(g), (y < 0) ? 8'h00 : ((y > 255) ? 8'hff : 8'(y))};
    endfunction

    // prediction from the window before the taken sample, then the window shifts
    always @(posedge i_clk) begin
        if (o_pix_valid === 1'b1) begin
            npix++;
            if (expq.size() == 0) cmp("pixel valid", 32'h0, 32'h1);
            else begin
                last = expq.pop_front();
                cmp("pixel", {24'h0, last[7:0]}, {24'h0, o_pix_y});
            end
        end
        if (pix_valid && !i_rst) begin
            expq.push_back(model(sh[1]));
            for (int i = 4; i > 0; i--) win[i] = win[i-1];
            win[0] = pix_y;
        end
    end

    // clock enable, dropped at random while ce_rnd is set
    always @(posedge i_clk) ce <= !ce_rnd || ($urandom % 3 != 0);

    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        void'($urandom(32'heb34));
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 2; k++) rd_chk(k);
        $display("test reset values done");
        // coefficient pair: all ones, unity, then random words and strobes
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 32'hffffffff : ((k == 1) ? 32'h01000100 : $urandom);
            wr_reg(0, d, (k < 2) ? 4'hf : 4'($urandom));
            @(posedge i_clk);
            cmp("odd tap port", {22'h0, sh[0][25:16]}, {22'h0, odd});
            cmp("even tap port", {22'h0, sh[0][9:0]}, {22'h0, even});
            rd_chk(0);
        end
        $display("test coefficient pair done");
        // unmapped place refuses, status ignores writes; clock enable drops at random meanwhile
        ce_rnd <= 1'b1;
        axi_wr(12'h00c, 32'h0, 4'hf, r);
        cmp("unmapped write response", {30'h0, `RVLE_RESP_SLVERR}, {30'h0, r});
        axi_rd(12'h00c, d, r);
        cmp("unmapped read response", {30'h0, `RVLE_RESP_SLVERR}, {30'h0, r});
        cmp("unmapped read data", 32'h0, d);
        axi_wr(`RVLE_STAT_OFF, 32'hffffffff, 4'hf, r);
        cmp("status write response", {30'h0, `RVLE_RESP_OKAY}, {30'h0, r});
        rd_chk(0);
        ce_rnd <= 1'b0;
        $display("test unmapped access done");
        // every filter code, strong and cored corners, then random settings
        for (int k = 0; k < 12; k++) begin
            d = $urandom;
            d[17:16] = 2'(k);
            if (k < 4) d[15:0] = 16'hff00;
            else if (k < 8) d[7:0] = 8'hff;
            wr_reg(1, d, 4'hf);
            rd_chk(1);
            repeat (40) begin
                @(posedge i_clk);
                pix_valid <= ($urandom % 4) != 0;
                pix_y <= ($urandom % 3 == 0) ? {8{$urandom % 2 == 1}} : 8'($urandom);
            end
            @(posedge i_clk);
            pix_valid <= 1'b0;
            repeat (4) @(posedge i_clk);
            $display("test enhancer setting %0d done", k);
        end
        axi_rd(`RVLE_STAT_OFF, d, r);
        cmp("status word", {16'(npix), 4'h0, last}, d);
        $display("test status word done");
        end_of_test();
    end
endmodule // rvle_top_tb_top
`default_nettype wire
